// *** verilog/jls_pkg.sv ***
// package: constants and types shared by both ends of the link sync block
package jls_pkg;
  // ----------------------------------------
  // apb map and field layout
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_CFG   = 8'h04;
  localparam logic [7:0]  OFS_STAT  = 8'h08;
  localparam int          CT_SUB    = 0;
  localparam int          CT_ILAS   = 2;
  localparam int          CT_ALERT  = 3;
  localparam int          CT_TWO    = 4;
  localparam int          CT_K      = 8;
  localparam int          CT_TMO    = 16;
  localparam int          CF_DID    = 0;
  localparam int          CF_BID    = 8;
  localparam int          CF_SCR    = 12;
  localparam logic [31:0] CTRL_RST  = 32'h0004_0f14;
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  // ----------------------------------------
  // control characters
  // ----------------------------------------
  localparam logic [7:0]  K_285     = 8'hbc;
  localparam logic [7:0]  K_280     = 8'h1c;
  localparam logic [7:0]  K_283     = 8'h7c;
  localparam logic [7:0]  K_284     = 8'h9c;
  // ----------------------------------------
  // fixed link parameters, coded value minus one where a count
  // ----------------------------------------
  localparam logic [7:0]  F_M1_ONE  = 8'h03;
  localparam logic [7:0]  F_M1_TWO  = 8'h01;
  localparam logic [4:0]  L_M1_ONE  = 5'h00;
  localparam logic [4:0]  L_M1_TWO  = 5'h01;
  localparam logic [7:0]  M_M1      = 8'h01;
  localparam logic [4:0]  N_M1      = 5'h0d;
  localparam logic [4:0]  NP_M1     = 5'h0f;
  localparam logic [1:0]  CS_VAL    = 2'h1;
  localparam logic [2:0]  JESDV     = 3'h1;
  localparam logic [4:0]  S_M1      = 5'h00;
  localparam logic [3:0]  ADJCNT    = 4'h0;
  localparam logic        ADJDIR    = 1'b0;
  localparam logic        PHADJ     = 1'b0;
  localparam logic        HD        = 1'b0;
  localparam logic [4:0]  CF        = 5'h00;
  // ----------------------------------------
  // sequence counts
  // ----------------------------------------
  localparam logic [2:0]  DETECT_LAST = 3'h4;
  localparam logic [2:0]  CGS_LAST    = 3'h3;
  localparam logic [1:0]  ILAS_LAST   = 2'h3;
  localparam logic [7:0]  CFG_FIRST   = 8'h02;
  localparam logic [7:0]  CFG_LAST    = 8'h0f;
  localparam logic [3:0]  SYSREF_LEN  = 4'h4;
  typedef enum logic [2:0] {
    ST_DATA   = 3'b000,
    ST_DETECT = 3'b001,
    ST_CGS    = 3'b011,
    ST_REL    = 3'b010,
    ST_ILAS   = 3'b110
  } jls_state_t;
endpackage

// *** verilog/jls_link_if.sv ***
// interface: sync request, sysref and two octet lanes between the ends
`timescale 1ns/1ps
`default_nettype none
interface jls_link_if;
  logic            sync_n;
  logic            sysref;
  logic [1:0][7:0] lane_data;
  logic [1:0]      lane_k;
  modport dev  (input sync_n, input sysref, output lane_data, output lane_k);
  modport host (output sync_n, output sysref, input lane_data, input lane_k);
endinterface
`default_nettype wire

// *** verilog/jls_lfc.sv ***
// frame and multiframe position counters with realign inputs
`timescale 1ns/1ps
`default_nettype none
module jls_lfc (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       realign,
  input  wire logic       mf_reset,
  input  wire logic [7:0] f_m1,
  input  wire logic [4:0] k_m1,
  output logic            frame_start,
  output logic            mf_start,
  output logic [7:0]      oct,
  output logic [7:0]      mf_pos
);
  logic [7:0] oct_reg;
  logic [4:0] frm_reg;
  logic [7:0] pos_reg;
  logic [4:0] frm;

  // realign makes this very cycle position zero of frame and multiframe
  assign oct         = realign ? 8'h00 : oct_reg;
  assign frm         = (realign || mf_reset) ? 5'h00 : frm_reg;
  assign mf_pos      = (realign || mf_reset) ? 8'h00 : pos_reg;
  assign frame_start = realign || (oct_reg == 8'h00);
  assign mf_start    = frame_start && (mf_reset || frm == 5'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oct_reg <= 8'h00;
      frm_reg <= 5'h00;
      pos_reg <= 8'h00;
    end else if (oct >= f_m1) begin
      oct_reg <= 8'h00;
      frm_reg <= (frm >= k_m1) ? 5'h00 : frm + 5'h01;
      pos_reg <= (frm >= k_m1) ? 8'h00 : mf_pos + 8'h01;
    end else begin
      oct_reg <= oct + 8'h01;
      frm_reg <= frm;
      pos_reg <= mf_pos + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verilog/jls_tx_dev.sv ***
// device end: sync request handling, alignment sequence and lane framing
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - receiver drives active-low sync request
// - receiver may request sync any time
// - request seen on fifth local frame edge
// - K28.5 stream from next frame boundary
// - receiver releases after four K28.5
// - all lanes align together
// - receiver requests may be combined
// - subclass 0 release ends at frame boundary
// - subclass 0 alignment: marker reset, four multiframes
// - alignment disabled: data follows directly
// - subclass 0 never realigns clocks
// - subclass 1 sysref edge resets clocks
// - alert mode: first pulse arms, second resets
// - alert mode disarms after multiframe timeout
// - subclass 2 sync release realigns clocks
// - receiver parameters match device parameters
// - counts coded minus one, fixed values
// - checksum is field sum modulo 256
// - single-lane or two-lane mapping
// - subclass 1 release ends at multiframe
// - alignment multiframes open K28.0, close K28.3
module jls_tx_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [13:0] sample_a,
  input  wire logic        ovr_a,
  input  wire logic [13:0] sample_b,
  input  wire logic        ovr_b,
  output logic             link_up,
  jls_link_if.dev          link
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  jls_pkg::jls_state_t state_reg, state_next;
  logic [31:0] ctrl_reg, cfg_reg, rd_data;
  logic [1:0]  sub;
  logic        ilas_en, alert_en, two_lane, scr;
  logic [4:0]  k_m1, l_m1, lid;
  logic [7:0]  f_m1, tmo, did, mf_last;
  logic [3:0]  bid;
  logic        setup, access, hit;
  logic        sync_meta, sync_s, sref_meta, sref_s, sref_d, sref_rise;
  logic        frame_start, mf_start, realign, mf_reset, rel_edge, entering;
  logic [7:0]  oct, mf_pos, ilas_cnt, ilas_cnt_reg, tmo_cnt_reg;
  logic [1:0]  ilas_mf, mf_idx_reg;
  logic [2:0]  det_cnt_reg;
  logic        armed_reg;
  logic [15:0] hold_a_reg, hold_b_reg, wa, wb;
  logic [7:0]  cfg_oct [2][14];
  logic [7:0]  sym_d [2];
  logic        sym_k [2];

  // ----------------------------------------
  // settings
  // ----------------------------------------
  assign sub      = ctrl_reg[jls_pkg::CT_SUB +: 2];
  assign ilas_en  = ctrl_reg[jls_pkg::CT_ILAS];
  assign alert_en = ctrl_reg[jls_pkg::CT_ALERT];
  assign two_lane = ctrl_reg[jls_pkg::CT_TWO];
  assign k_m1     = ctrl_reg[jls_pkg::CT_K +: 5];
  assign tmo      = ctrl_reg[jls_pkg::CT_TMO +: 8];
  assign did      = cfg_reg[jls_pkg::CF_DID +: 8];
  assign bid      = cfg_reg[jls_pkg::CF_BID +: 4];
  assign scr      = cfg_reg[jls_pkg::CF_SCR];
  assign f_m1     = two_lane ? jls_pkg::F_M1_TWO : jls_pkg::F_M1_ONE;
  assign l_m1     = two_lane ? jls_pkg::L_M1_TWO : jls_pkg::L_M1_ONE;
  assign mf_last  = 8'(({8'h00, f_m1} + 16'h1) * ({11'h0, k_m1} + 16'h1) - 16'h1);

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign hit    = paddr == jls_pkg::OFS_CTRL || paddr == jls_pkg::OFS_CFG ||
                  paddr == jls_pkg::OFS_STAT;

  always_comb begin
    case (paddr)
      jls_pkg::OFS_CTRL: rd_data = ctrl_reg;
      jls_pkg::OFS_CFG:  rd_data = cfg_reg;
      jls_pkg::OFS_STAT: rd_data = {27'h0, link_up, armed_reg, state_reg};
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= jls_pkg::CTRL_RST;
      cfg_reg  <= jls_pkg::CFG_RST;
    end else if (access && pwrite) begin
      if (paddr == jls_pkg::OFS_CTRL) ctrl_reg <= pwdata;
      if (paddr == jls_pkg::OFS_CFG) cfg_reg <= pwdata;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= 1'b0;
      sync_s    <= 1'b0;
      sref_meta <= 1'b0;
      sref_s    <= 1'b0;
      sref_d    <= 1'b0;
    end else begin
      sync_meta <= link.sync_n;
      sync_s    <= sync_meta;
      sref_meta <= link.sysref;
      sref_s    <= sref_meta;
      sref_d    <= sref_s;
    end
  end
  assign sref_rise = sref_s && !sref_d;

  // ----------------------------------------
  // local clocks and alert mode
  // ----------------------------------------
  // subclass 0 never realigns; only the marker reset before alignment
  assign realign = (sub == 2'd1 && sref_rise && (!alert_en || armed_reg)) ||
                   (sub == 2'd2 && state_reg == jls_pkg::ST_CGS && sync_s);
  assign mf_reset = sub == 2'd0 && state_reg == jls_pkg::ST_REL && frame_start &&
                    sync_s && ilas_en;

  jls_lfc u_lfc (
    .pclk        (pclk),
    .presetn     (presetn),
    .realign     (realign),
    .mf_reset    (mf_reset),
    .f_m1        (f_m1),
    .k_m1        (k_m1),
    .frame_start (frame_start),
    .mf_start    (mf_start),
    .oct         (oct),
    .mf_pos      (mf_pos)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg   <= 1'b0;
      tmo_cnt_reg <= 8'h00;
    end else if (sub != 2'd1 || !alert_en) begin
      armed_reg   <= 1'b0;
      tmo_cnt_reg <= 8'h00;
    end else if (sref_rise) begin
      armed_reg   <= !armed_reg;
      tmo_cnt_reg <= 8'h00;
    end else if (armed_reg && mf_start) begin
      if (tmo_cnt_reg + 8'h01 >= tmo) armed_reg <= 1'b0;
      tmo_cnt_reg <= tmo_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // sync state machine, one for all lanes
  // ----------------------------------------
  assign rel_edge = (sub == 2'd0) ? frame_start : mf_start;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      jls_pkg::ST_DATA, jls_pkg::ST_ILAS: begin
        if (!sync_s) begin
          state_next = jls_pkg::ST_DETECT;
        end else if (state_reg == jls_pkg::ST_ILAS && mf_start &&
                     mf_idx_reg == jls_pkg::ILAS_LAST) begin
          state_next = jls_pkg::ST_DATA;
        end
      end
      jls_pkg::ST_DETECT: begin
        if (frame_start && det_cnt_reg == jls_pkg::DETECT_LAST) begin
          state_next = jls_pkg::ST_CGS;
        end
      end
      jls_pkg::ST_CGS: begin
        if (sync_s) state_next = jls_pkg::ST_REL;
      end
      jls_pkg::ST_REL: begin
        if (!sync_s) begin
          state_next = jls_pkg::ST_CGS;
        end else if (rel_edge) begin
          state_next = ilas_en ? jls_pkg::ST_ILAS : jls_pkg::ST_DATA;
        end
      end
      default: state_next = jls_pkg::ST_CGS;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= jls_pkg::ST_CGS;
      det_cnt_reg <= 3'h0;
      link_up     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      det_cnt_reg <= (state_reg != jls_pkg::ST_DETECT) ? 3'h0 :
                     det_cnt_reg + 3'(frame_start);
      link_up     <= state_next == jls_pkg::ST_DATA;
    end
  end

  // ----------------------------------------
  // alignment sequence counters
  // ----------------------------------------
  assign entering = state_reg != jls_pkg::ST_ILAS && state_next == jls_pkg::ST_ILAS;
  assign ilas_cnt = entering ? 8'h00 : ilas_cnt_reg;
  assign ilas_mf  = entering ? 2'h0 : mf_idx_reg + 2'(mf_start);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilas_cnt_reg <= 8'h00;
      mf_idx_reg   <= 2'h0;
    end else begin
      ilas_cnt_reg <= ilas_cnt + 8'h01;
      mf_idx_reg   <= ilas_mf;
    end
  end

  // ----------------------------------------
  // link configuration octets per lane
  // ----------------------------------------
  always_comb begin
    lid = 5'h00;
    for (int l = 0; l < 2; l++) begin
      lid = 5'(l);
      cfg_oct[l][0]  = did;
      cfg_oct[l][1]  = {jls_pkg::ADJCNT, bid};
      cfg_oct[l][2]  = {1'b0, jls_pkg::ADJDIR, jls_pkg::PHADJ, lid};
      cfg_oct[l][3]  = {scr, 2'b00, l_m1};
      cfg_oct[l][4]  = f_m1;
      cfg_oct[l][5]  = {3'b000, k_m1};
      cfg_oct[l][6]  = jls_pkg::M_M1;
      cfg_oct[l][7]  = {jls_pkg::CS_VAL, 1'b0, jls_pkg::N_M1};
      cfg_oct[l][8]  = {1'b0, sub, jls_pkg::NP_M1};
      cfg_oct[l][9]  = {jls_pkg::JESDV, jls_pkg::S_M1};
      cfg_oct[l][10] = {jls_pkg::HD, 2'b00, jls_pkg::CF};
      cfg_oct[l][11] = 8'h00;
      cfg_oct[l][12] = 8'h00;
      // wraps naturally at 8 bits
      cfg_oct[l][13] = 8'(did + bid + lid + scr + l_m1 + f_m1 + k_m1 + jls_pkg::M_M1 +
                          jls_pkg::CS_VAL + jls_pkg::N_M1 + sub + jls_pkg::NP_M1 +
                          jls_pkg::JESDV + jls_pkg::S_M1 + jls_pkg::HD + jls_pkg::CF +
                          jls_pkg::ADJCNT + jls_pkg::ADJDIR + jls_pkg::PHADJ);
    end
  end

  // ----------------------------------------
  // sample framing
  // ----------------------------------------
  function automatic logic [7:0] data_octet(input logic [15:0] a, input logic [15:0] b,
                                            input logic [7:0] o, input logic two,
                                            input int lane);
    logic [15:0] w;
    w = two ? ((lane == 0) ? a : b) : (o[1] ? b : a);
    data_octet = o[0] ? w[7:0] : w[15:8];
  endfunction

  assign wa = (oct == 8'h00) ? {sample_a, ovr_a, 1'b0} : hold_a_reg;
  assign wb = (oct == 8'h00) ? {sample_b, ovr_b, 1'b0} : hold_b_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_a_reg <= 16'h0000;
      hold_b_reg <= 16'h0000;
    end else if (frame_start) begin
      hold_a_reg <= wa;
      hold_b_reg <= wb;
    end
  end

  // ----------------------------------------
  // lane symbols, chosen from the next state so boundaries line up
  // ----------------------------------------
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      sym_k[l] = 1'b0;
      sym_d[l] = 8'h00;
      if (l == 0 || two_lane) begin
        case (state_next)
          jls_pkg::ST_CGS, jls_pkg::ST_REL: begin
            sym_k[l] = 1'b1;
            sym_d[l] = jls_pkg::K_285;
          end
          jls_pkg::ST_ILAS: begin
            sym_k[l] = 1'b1;
            if (mf_pos == 8'h00) begin
              sym_d[l] = jls_pkg::K_280;
            end else if (mf_pos == mf_last) begin
              sym_d[l] = jls_pkg::K_283;
            end else if (ilas_mf == 2'h1 && mf_pos == 8'h01) begin
              sym_d[l] = jls_pkg::K_284;
            end else if (ilas_mf == 2'h1 && mf_pos >= jls_pkg::CFG_FIRST &&
                         mf_pos <= jls_pkg::CFG_LAST) begin
              sym_k[l] = 1'b0;
              sym_d[l] = cfg_oct[l][4'(mf_pos - jls_pkg::CFG_FIRST)];
            end else begin
              sym_k[l] = 1'b0;
              sym_d[l] = ilas_cnt;
            end
          end
          default: sym_d[l] = data_octet(wa, wb, oct, two_lane, l);
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.lane_data <= '0;
      link.lane_k    <= 2'b00;
    end else begin
      for (int l = 0; l < 2; l++) begin
        link.lane_data[l] <= sym_d[l];
        link.lane_k[l]    <= sym_k[l];
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/jls_rx_host.sv ***
// receiver end: sync requests, sysref pulses and code-group detection
`timescale 1ns/1ps
`default_nettype none
module jls_rx_host (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic resync,
  input  wire logic peer_sync_n,
  input  wire logic sysref_req,
  input  wire logic two_lane,
  output logic      sync_released,
  output logic      link_up,
  jls_link_if.host  link
);
  // ----------------------------------------
  // lane synchronisers
  // ----------------------------------------
  logic [1:0][7:0] d_meta, d_s;
  logic [1:0]      k_meta, k_s;
  logic            own_req_reg, is_k;
  logic [2:0]      kcnt_reg;
  logic [3:0]      sref_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_meta <= '0;
      d_s    <= '0;
      k_meta <= 2'b00;
      k_s    <= 2'b00;
    end else begin
      d_meta <= link.lane_data;
      d_s    <= d_meta;
      k_meta <= link.lane_k;
      k_s    <= k_meta;
    end
  end

  // lane 1 only counts when the device runs two lanes
  assign is_k = k_s[0] && d_s[0] == jls_pkg::K_285 &&
                (!two_lane || (k_s[1] && d_s[1] == jls_pkg::K_285));

  // ----------------------------------------
  // sync request
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_req_reg <= 1'b1;
      kcnt_reg    <= 3'h0;
    end else if (resync) begin
      own_req_reg <= 1'b1;
      kcnt_reg    <= 3'h0;
    end else if (own_req_reg) begin
      if (!is_k) begin
        kcnt_reg <= 3'h0;
      end else if (kcnt_reg == jls_pkg::CGS_LAST) begin
        own_req_reg <= 1'b0;
      end else begin
        kcnt_reg <= kcnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sync_n   <= 1'b0;
      sync_released <= 1'b0;
      link_up       <= 1'b0;
    end else begin
      link.sync_n   <= !own_req_reg && peer_sync_n;
      sync_released <= !own_req_reg;
      link_up       <= !own_req_reg && !resync && (link_up || !is_k);
    end
  end

  // ----------------------------------------
  // sysref pulse
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sref_cnt_reg <= 4'h0;
      link.sysref  <= 1'b0;
    end else begin
      if (sysref_req && sref_cnt_reg == 4'h0) begin
        sref_cnt_reg <= jls_pkg::SYSREF_LEN;
      end else if (sref_cnt_reg != 4'h0) begin
        sref_cnt_reg <= sref_cnt_reg - 4'h1;
      end
      link.sysref <= sref_cnt_reg != 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** bench/jls_link_sva.sv ***
// checker: relations on the link wires between the two ends
`timescale 1ns/1ps
`default_nettype none
module jls_link_sva (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            sync_n,
  input wire logic            sysref,
  input wire logic [1:0][7:0] lane_data,
  input wire logic [1:0]      lane_k
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] low_cnt;
  wire        kc   = lane_k[0] && lane_data[0] == jls_pkg::K_285;
  wire        k280 = lane_k[0] && lane_data[0] == jls_pkg::K_280;
  wire        k283 = lane_k[0] && lane_data[0] == jls_pkg::K_283;
  // --
  // request age, saturating so a long hold stays covered
  // --
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 6'h00;
    else if (sync_n) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
  end
  sequence s_ref_pulse;
    sysref [*4] ##1 !sysref;
  endsequence
  // --
  // assertions
  // --
  a_reset_k_start: assert property ($rose(presetn) |-> ##1 kc)
    else $error("lanes not in code-group state after reset");
  a_reset_req_low: assert property ($rose(presetn) |-> !sync_n ##1 !sync_n)
    else $error("request not held after reset");
  a_req_gives_k: assert property (low_cnt >= 6'h30 |-> kc)
    else $error("long request without code-group stream");
  // receiver sees lanes two flops late and releases two cycles after its count
  a_release_after_four: assert property ($rose(sync_n) |->
    $past(kc, 4) && $past(kc, 5) && $past(kc, 6) && $past(kc, 7))
    else $error("release without four code-groups");
  a_k_ends_bounded: assert property ($rose(sync_n) |-> ##[1:200] !kc)
    else $error("code-group stream never ended");
  a_ilas_mf_close: assert property (k280 |-> ##[1:127] k283)
    else $error("alignment multiframe not closed");
  a_lanes_agree: assert property (lane_k[1] |-> lane_k[0] && lane_data[1] == lane_data[0])
    else $error("control characters differ between lanes");
  a_ref_width: assert property ($rose(sysref) |-> s_ref_pulse)
    else $error("sysref pulse width wrong");
endmodule
`default_nettype wire

// *** bench/jls_tx_link_sync_tb.sv ***
// testbench: both link ends joined, apb setup and sync scenarios
`timescale 1ns/1ps
`default_nettype none
module jls_tx_link_sync_tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, resync, peer_sync_n, sysref_req, two_lane;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, ctl, cfg;
  logic        pready, pslverr, e, dev_up, host_up, rel, ovr_a, ovr_b;
  logic [13:0] sample_a, sample_b;
  logic [7:0]  oct [14];
  logic [15:0] h0, h1;
  logic        dchk = 1'b0;
  int          seed, n_errors, check_count, i, cap = 14;
  jls_link_if link_i ();
  jls_link_sva jls_link_sva_i (.pclk, .presetn, .sync_n(link_i.sync_n),
    .sysref(link_i.sysref), .lane_data(link_i.lane_data), .lane_k(link_i.lane_k));
  jls_tx_dev jls_tx_dev_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .sample_a, .ovr_a, .sample_b, .ovr_b, .link_up(dev_up),
    .link(link_i));
  jls_rx_host jls_rx_host_i (.pclk, .presetn, .resync, .peer_sync_n, .sysref_req,
    .two_lane, .sync_released(rel), .link_up(host_up), .link(link_i));
  always #10 pclk = ~pclk;
  always @(posedge pclk) {sample_a, ovr_a, sample_b, ovr_b} <= 30'($random(seed));
  // --
  // grab the config octets that follow the K28.4 marker
  // --
  always @(posedge pclk) begin
    if (cap < 14) oct[cap] = link_i.lane_data[0];
    if (cap < 14) cap++;
    if (link_i.lane_k[0] && link_i.lane_data[0] == jls_pkg::K_284) cap = 0;
  end
  // --
  // two-lane data: lane 0 octet is msb of the word just taken or lsb of the one before
  // --
  always @(posedge pclk) begin
    if (dchk && dev_up === 1'b1) begin
      chk(link_i.lane_data[0], (link_i.lane_data[0] == h0[15:8]) ? h0[15:8] : h1[7:0]);
    end
    h1 <= h0;
    h0 <= {sample_a, ovr_a, 1'b0};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle cycle after each transfer keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one task serves both pulse inputs
  task automatic pulse(input logic to_sysref);
    if (to_sysref) sysref_req <= 1'b1;
    else resync <= 1'b1;
    @(posedge pclk);
    sysref_req <= 1'b0;
    resync <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
  function automatic logic [7:0] fsum(input logic [31:0] c, input logic [31:0] g);
    return g[7:0] + g[11:8] + g[12] + (c[4] ? jls_pkg::L_M1_TWO : jls_pkg::L_M1_ONE)
      + (c[4] ? jls_pkg::F_M1_TWO : jls_pkg::F_M1_ONE) + c[12:8] + jls_pkg::M_M1
      + jls_pkg::CS_VAL + jls_pkg::N_M1 + c[1:0] + jls_pkg::NP_M1 + jls_pkg::JESDV;
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
  initial begin
    seed = 83478;
    {presetn, psel, penable, pwrite, resync, sysref_req, paddr, pwdata} = '0;
    {peer_sync_n, two_lane} = 2'b11;
    {sample_a, ovr_a, sample_b, ovr_b} = 30'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, jls_pkg::OFS_CTRL, 32'h0);
    chk(q, jls_pkg::CTRL_RST);
    apb(1'b0, 8'h0c, 32'h0);
    chk({q[31:1], e}, 32'h1);
    cfg = 32'($random(seed)) & 32'h1fff;
    apb(1'b1, jls_pkg::OFS_CFG, cfg);
    apb(1'b0, jls_pkg::OFS_CFG, 32'h0);
    chk(q, cfg);
    for (i = 0; i < 6; i++) begin
      ctl = 32'h0004_0f00 | {27'h0, i[0], 1'b0, i < 3, 2'(i % 3)};
      apb(1'b1, jls_pkg::OFS_CTRL, ctl);
      two_lane <= i[0];
      peer_sync_n <= (i != 2);
      pulse(1'b0);
      if (i % 3 == 1) pulse(1'b1);
      if (i == 2) repeat (60) @(posedge pclk);
      peer_sync_n <= 1'b1;
      // a hang here is left to the watchdog
      while (!(dev_up === 1'b1 && host_up === 1'b1)) begin
        @(posedge pclk);
      end
      dchk <= i[0];
      apb(1'b0, jls_pkg::OFS_STAT, 32'h0);
      chk(q & 32'h1f, 32'h10);
      chk({rel, link_i.lane_k}, 3'b100);
      if (i < 3) chk(oct[4], ctl[4] ? jls_pkg::F_M1_TWO : jls_pkg::F_M1_ONE);
      if (i < 3) chk(oct[7], {jls_pkg::CS_VAL, 1'b0, jls_pkg::N_M1});
      if (i < 3) chk(oct[13], fsum(ctl, cfg));
      repeat (16) @(posedge pclk);
      dchk <= 1'b0;
    end
    apb(1'b1, jls_pkg::OFS_CTRL, 32'h0004_0f1d);
    pulse(1'b1);
    apb(1'b0, jls_pkg::OFS_STAT, 32'h0);
    chk(q[3], 1'b1);
    pulse(1'b1);
    apb(1'b0, jls_pkg::OFS_STAT, 32'h0);
    chk(q[3], 1'b0);
    pulse(1'b1);
    apb(1'b0, jls_pkg::OFS_STAT, 32'h0);
    chk(q[3], 1'b1);
    repeat (200) @(posedge pclk);
    apb(1'b0, jls_pkg::OFS_STAT, 32'h0);
    chk(q[3], 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
